// ---- hdl/rpsel_bank.sv ----
/*
  Selector bank: 64 four-bit slots, write port, registered read port
  and all selector fields brought out in parallel for the crossbar.
  Assumes the top has already filtered writes against the lock.
*/
`timescale 1ns/1ps
module rpsel_bank (
  input  wire logic   clk,   // System clock
  input  wire logic   srst,  // Synchronous reset, active high
  input  wire logic   ce,    // Clock enable, freezes the bank when low
  rpsel_sel_if.bank   sel    // Selector port
);

  logic [rpsel_pkg::SELW-1:0] mem_q [rpsel_pkg::NSEL];  // Selector slots
  logic [rpsel_pkg::SELW-1:0] rdata_q;                  // Read data register

  // Slots reset to code 0, no connection for pin selectors, so no pin is driven after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int k = 0; k < rpsel_pkg::NSEL; k++) begin
        mem_q[k] <= rpsel_pkg::SEL_RST;
      end
      rdata_q <= rpsel_pkg::SEL_RST;
    end else if (ce) begin
      if (sel.we) begin
        mem_q[sel.waddr] <= sel.wdata;
      end
      rdata_q <= mem_q[sel.raddr];
    end
  end

  assign sel.rdata = rdata_q;

  // Parallel taps: inputs at the bottom, pin selectors from OUT_BASE up
  for (genvar g = 0; g < rpsel_pkg::NIN; g++) begin : g_in
    assign sel.in_sel[g*rpsel_pkg::SELW +: rpsel_pkg::SELW] = mem_q[g];
  end
  for (genvar g = 0; g < rpsel_pkg::NPIN; g++) begin : g_out
    assign sel.out_sel[g*rpsel_pkg::SELW +: rpsel_pkg::SELW] =
      mem_q[int'(rpsel_pkg::OUT_BASE) + g];
  end

endmodule

// ---- hdl/rpsel_pkg.sv ----
/*
  Constants for the remappable pin select crossbar: sizes, selector
  layout, lock bit positions, pin presence masks and decode tables.
  Assumes nothing of its surroundings; every design file refers to it
  by rpsel_pkg::name.
*/
package rpsel_pkg;

  // Sizes of the crossbar
  localparam int NPIN     = 32;   // Remappable pins, four sets of eight
  localparam int NIN      = 24;   // Remappable peripheral inputs
  localparam int NOUT     = 17;   // Remappable peripheral outputs
  localparam int SELW     = 4;    // Width of one selector field
  localparam int ADRW     = 6;    // Selector address width
  localparam int SETPINS  = 8;    // Pins in one pin set
  localparam int NSEL     = 64;   // Selector slots in the bank

  // Selector address map: inputs at 0..23, pins at 32..63
  localparam logic [5:0] OUT_BASE = 6'h20;
  localparam int         OUT_FLAG = 5;    // Address bit marking a pin selector

  // Lock bit positions in their configuration words
  localparam int LOCK_BIT   = 13;   // mapping_write_lock in system_config_register
  localparam int ONEWAY_BIT = 29;   // single_session_lock in boot_config_word3

  // Reset value of every selector: no connection for pins, pin 0 of its set for inputs
  localparam logic [3:0] SEL_RST  = 4'h0;
  localparam int         RSV_BIT  = 3;    // Selector codes 1000 and up are reserved

  // Pin presence per package; bit n is pin n of the crossbar
  localparam logic [31:0] ONLY44_MASK = 32'hC020_E0A0;  // Only on 44-pin parts
  localparam logic [31:0] NOT28_MASK  = 32'h20C0_0040;  // Missing on 28-pin parts
  localparam logic [31:0] ALL_PINS    = 32'hFFFF_FFFF;

  // Peripheral output indices on the crossbar's output side
  localparam logic [4:0] PO_UART1_TRANSMIT     = 5'h00;
  localparam logic [4:0] PO_UART2_RTS          = 5'h01;
  localparam logic [4:0] PO_SPI1_SLAVE_SELECT  = 5'h02;
  localparam logic [4:0] PO_COMPARE1_OUTPUT    = 5'h03;
  localparam logic [4:0] PO_COMPARATOR2_RESULT = 5'h04;
  localparam logic [4:0] PO_SPI1_SERIAL_OUT    = 5'h05;
  localparam logic [4:0] PO_SPI2_SERIAL_OUT    = 5'h06;
  localparam logic [4:0] PO_COMPARE2_OUTPUT    = 5'h07;
  localparam logic [4:0] PO_COMPARATOR3_RESULT = 5'h08;
  localparam logic [4:0] PO_COMPARE4_OUTPUT    = 5'h09;
  localparam logic [4:0] PO_COMPARE5_OUTPUT    = 5'h0A;
  localparam logic [4:0] PO_REFCLK_OUTPUT      = 5'h0B;
  localparam logic [4:0] PO_UART1_RTS          = 5'h0C;
  localparam logic [4:0] PO_UART2_TRANSMIT     = 5'h0D;
  localparam logic [4:0] PO_SPI2_SLAVE_SELECT  = 5'h0E;
  localparam logic [4:0] PO_COMPARE3_OUTPUT    = 5'h0F;
  localparam logic [4:0] PO_COMPARATOR1_RESULT = 5'h10;
  localparam logic [4:0] PO_NONE               = 5'h1F;  // No connect or reserved

  // Output decode: per pin set, codes 0000..0111 to a peripheral output
  localparam logic [4:0] OUT_MAP [4][8] = '{
    '{PO_NONE, PO_UART1_TRANSMIT, PO_UART2_RTS, PO_SPI1_SLAVE_SELECT,
      PO_NONE, PO_COMPARE1_OUTPUT, PO_NONE, PO_COMPARATOR2_RESULT},
    '{PO_NONE, PO_NONE, PO_NONE, PO_SPI1_SERIAL_OUT,
      PO_SPI2_SERIAL_OUT, PO_COMPARE2_OUTPUT, PO_NONE, PO_COMPARATOR3_RESULT},
    '{PO_NONE, PO_NONE, PO_NONE, PO_SPI1_SERIAL_OUT,
      PO_SPI2_SERIAL_OUT, PO_COMPARE4_OUTPUT, PO_COMPARE5_OUTPUT, PO_REFCLK_OUTPUT},
    '{PO_NONE, PO_UART1_RTS, PO_UART2_TRANSMIT, PO_NONE,
      PO_SPI2_SLAVE_SELECT, PO_COMPARE3_OUTPUT, PO_NONE, PO_COMPARATOR1_RESULT}};

  // Pin set served by each peripheral input, in input index order:
  // 0 int4, 1 t2 clock, 2 capture4, 3 spi1 select, 4 refclk in,
  // 5 int3, 6 t3 clock, 7 capture3, 8 uart1 cts, 9 uart2 rx, 10 spi1 in,
  // 11 int2, 12 t4 clock, 13 capture1, 14 capture5, 15 uart1 rx,
  // 16 uart2 cts, 17 spi2 in, 18 fault B,
  // 19 int1, 20 t5 clock, 21 capture2, 22 spi2 select, 23 fault A
  localparam logic [1:0] IN_SET [24] = '{
    2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
    2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h3, 2'h3, 2'h3, 2'h3, 2'h3};

endpackage

// ---- hdl/rpsel_sel_if.sv ----
/*
  Carrier between the crossbar top and its selector bank: one write
  port, one registered read port and every selector in parallel.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface rpsel_sel_if;
  logic                                      we;       // Write strobe
  logic [rpsel_pkg::ADRW-1:0]                waddr;    // Write address
  logic [rpsel_pkg::SELW-1:0]                wdata;    // Write data
  logic [rpsel_pkg::ADRW-1:0]                raddr;    // Read address
  logic [rpsel_pkg::SELW-1:0]                rdata;    // Registered read data
  logic [rpsel_pkg::NIN*rpsel_pkg::SELW-1:0]  in_sel;   // Input selectors
  logic [rpsel_pkg::NPIN*rpsel_pkg::SELW-1:0] out_sel;  // Pin selectors

  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata, input in_sel, input out_sel);
  modport bank (input we, input waddr, input wdata, input raddr,
                output rdata, output in_sel, output out_sel);
endinterface

// ---- hdl/rpsel_top.sv ----
/*
  Remappable pin select crossbar. Peripheral inputs each pick one pin of
  their pin set; each pin picks one peripheral output. A lock guards the
  selectors, with an optional one-way mode undone only by reset.
  Assumes the unlock sequence is decoded elsewhere and shown on
  UNLOCK_OK, and that pads, peripherals and software share CLK_SYS.
*/
`timescale 1ns/1ps

// Functional notes
// - Each peripheral input has 4-bit pin selector.
// - Each pin has 4-bit peripheral output selector.
// - Input and output selectors are fully independent.
// - Pin set one codes and pins.
// - Pin set two codes and pins.
// - Pin set three codes and pins.
// - Pin set four codes and pins.
// - Pin set one output code decode.
// - Pin set two output code decode.
// - Pin set three output code decode.
// - Pin set four output code decode.
// - Output code zero disconnects; selectors reset zero.
// - Locked selector writes complete but change nothing.
// - Lock is bit 13 of system config.
// - One-way mode forbids clearing a set lock.
// - Only reset clears an engaged one-way lock.
// - Unprogrammed boot word leaves one-way mode on.
// - Pins absent in package have no pad.
// - Remap output overrides digital, never analog functions.

module rpsel_top #(
  parameter int PKG_PINS = 44  // Package pin count: 28, 36 or 44
) (
  input  wire logic                         CLK_SYS,         // System clock
  input  wire logic                         SRST,            // Reset, high
  input  wire logic                         CE,              // Clock enable
  input  wire logic [31:0]                  BOOT_CFG3,       // boot_config_word3
  input  wire logic                         CFG_WR,          // Config word write
  input  wire logic [31:0]                  CFG_WDATA,       // Config write data
  input  wire logic                         UNLOCK_OK,       // Unlock done
  input  wire logic                         SEL_WR,          // Selector write
  input  wire logic [rpsel_pkg::ADRW-1:0]   SEL_ADDR,        // Write address
  input  wire logic [rpsel_pkg::SELW-1:0]   SEL_WDATA,       // Write data
  input  wire logic [rpsel_pkg::ADRW-1:0]   SEL_RADDR,       // Read address
  output logic      [rpsel_pkg::SELW-1:0]   SEL_RDATA,       // Read data
  output logic                              SEL_WR_BLOCKED,  // Write dropped
  output logic                              MAP_LOCK,        // mapping_write_lock
  output logic                              ONE_WAY,         // single_session_lock
  input  wire logic [rpsel_pkg::NPIN-1:0]   PAD_IN,          // Pad input levels
  input  wire logic [rpsel_pkg::NPIN-1:0]   PAD_ANALOG,      // Pin in analog mode
  output logic      [rpsel_pkg::NPIN-1:0]   PAD_OUT,         // Pad output data
  output logic      [rpsel_pkg::NPIN-1:0]   PAD_OE,          // Pad output enable
  output logic      [rpsel_pkg::NPIN-1:0]   PAD_REMAP_ACT,   // Remap owns pin
  input  wire logic [rpsel_pkg::NOUT-1:0]   PERIPH_OUT,      // Peripheral data
  input  wire logic [rpsel_pkg::NOUT-1:0]   PERIPH_OE,       // Peripheral enable
  output logic      [rpsel_pkg::NIN-1:0]    PERIPH_IN        // Peripheral inputs
);

  // Pins bonded out in this package; the rest have no pad behind them
  localparam logic [31:0] PRESENT =
    (PKG_PINS >= 44) ? rpsel_pkg::ALL_PINS :
    (PKG_PINS >= 36) ? ~rpsel_pkg::ONLY44_MASK :
                       ~(rpsel_pkg::ONLY44_MASK | rpsel_pkg::NOT28_MASK);

  localparam int SW = rpsel_pkg::SELW;  // Short alias for field width

  rpsel_sel_if sel ();  // Carrier to the selector bank

  logic                          lock_q;        // mapping_write_lock
  logic                          lock_d;        // Next lock value
  logic                          oneway_q;      // single_session_lock, caught at reset
  logic                          blocked_q;     // Dropped write pulse
  logic [rpsel_pkg::NPIN-1:0]    pad_out_q;     // Registered pad data
  logic [rpsel_pkg::NPIN-1:0]    pad_oe_q;      // Registered pad enable
  logic [rpsel_pkg::NPIN-1:0]    pad_act_q;     // Registered override flag
  logic [rpsel_pkg::NIN-1:0]     per_in_q;      // Registered peripheral inputs
  logic [rpsel_pkg::NPIN-1:0]    pad_out_d;     // Crossbar pad data
  logic [rpsel_pkg::NPIN-1:0]    pad_oe_d;      // Crossbar pad enable
  logic [rpsel_pkg::NPIN-1:0]    pad_act_d;     // Crossbar override flag
  logic [rpsel_pkg::NIN-1:0]     per_in_d;      // Crossbar peripheral inputs
  logic [31:0]                   pout_ext;      // Peripheral data, padded
  logic [31:0]                   poe_ext;       // Peripheral enable, padded
  logic [31:0]                   pad_dig;       // Pad levels seen as digital

  // Write decode
  wire cfg_take   = CFG_WR & UNLOCK_OK;
  wire want_lock  = CFG_WDATA[rpsel_pkg::LOCK_BIT];
  wire clr_stuck  = oneway_q & lock_q;
  wire addr_out   = SEL_ADDR[rpsel_pkg::OUT_FLAG];
  wire addr_ok    = addr_out | (int'(SEL_ADDR) < rpsel_pkg::NIN);
  wire sel_take   = SEL_WR & ~lock_q & addr_ok;
  wire sel_drop   = SEL_WR & ~sel_take;

  // Lock next value; a clear is refused while one-way mode holds it
  always_comb begin
    lock_d = lock_q;
    if (cfg_take) begin
      if (want_lock) begin
        lock_d = 1'b1;
      end else if (!clr_stuck) begin
        lock_d = 1'b0;
      end
    end
  end

  // Lock and one-way flag; reset is the only path out of one-way lock.
  // One-way mode is sampled from the boot word while reset is held, so
  // an erased word (all ones) keeps it on.
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      lock_q   <= 1'b0;
      oneway_q <= BOOT_CFG3[rpsel_pkg::ONEWAY_BIT];
    end else if (CE) begin
      lock_q   <= lock_d;
    end
  end

  // Bank write and read requests; a locked or unmapped write never reaches the bank
  assign sel.we    = sel_take & CE;
  assign sel.waddr = SEL_ADDR;
  assign sel.wdata = SEL_WDATA;
  assign sel.raddr = SEL_RADDR;

  rpsel_bank u_bank (
    .clk  (CLK_SYS),
    .srst (SRST),
    .ce   (CE),
    .sel  (sel)
  );

  // Padding lets the no-connect index fall on a constant zero
  assign pout_ext = 32'(PERIPH_OUT);
  assign poe_ext  = 32'(PERIPH_OE);
  // Analog pins read as low and absent pins as low
  assign pad_dig  = 32'(PAD_IN) & ~32'(PAD_ANALOG) & PRESENT;

  // Pin side: each pin decodes its own selector within its set
  for (genvar p = 0; p < rpsel_pkg::NPIN; p++) begin : g_pin
    wire [SW-1:0] code = sel.out_sel[p*SW +: SW];
    wire [4:0]    pidx = code[rpsel_pkg::RSV_BIT] ? rpsel_pkg::PO_NONE :
                         rpsel_pkg::OUT_MAP[p/rpsel_pkg::SETPINS][code[2:0]];
    wire          live = (pidx != rpsel_pkg::PO_NONE) &
                         PRESENT[p] & ~PAD_ANALOG[p];
    assign pad_act_d[p] = live;
    assign pad_out_d[p] = live & pout_ext[pidx];
    assign pad_oe_d[p]  = live & poe_ext[pidx];
  end

  // Input side: each input picks pin set*8 + code from its own set.
  // Inputs and pins decode from separate selectors, so one peripheral's
  // input and output may sit on unrelated pins.
  for (genvar i = 0; i < rpsel_pkg::NIN; i++) begin : g_in
    wire [SW-1:0] code = sel.in_sel[i*SW +: SW];
    wire [4:0]    pin  = {rpsel_pkg::IN_SET[i], code[2:0]};
    assign per_in_d[i] = ~code[rpsel_pkg::RSV_BIT] & pad_dig[pin];
  end

  // Output registers; the crossbar adds one cycle of latency so every
  // pad and peripheral line leaves from a flip-flop.
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pad_out_q <= '0;
      pad_oe_q  <= '0;
      pad_act_q <= '0;
      per_in_q  <= '0;
      blocked_q <= 1'b0;
    end else if (CE) begin
      pad_out_q <= pad_out_d;
      pad_oe_q  <= pad_oe_d;
      pad_act_q <= pad_act_d;
      per_in_q  <= per_in_d;
      blocked_q <= sel_drop;
    end
  end

  // Ports
  assign PAD_OUT        = pad_out_q;
  assign PAD_OE         = pad_oe_q;
  assign PAD_REMAP_ACT  = pad_act_q;
  assign PERIPH_IN      = per_in_q;
  assign MAP_LOCK       = lock_q;
  assign ONE_WAY        = oneway_q;
  assign SEL_WR_BLOCKED = blocked_q;
  assign SEL_RDATA      = sel.rdata;

endmodule

// ---- verif/rpsel_far_model.sv ----
/*
  Far side of the crossbar: peripherals and pads marking one source each.
  Assumes the bench changes its controls at clock edges.
*/
`timescale 1ns/1ps
module rpsel_far_model (
  input  wire logic [4:0]  per_sel,  // Peripheral output that is marked
  input  wire logic [4:0]  pin_sel,  // Pad that is marked
  input  wire logic        inv,      // Mark low among highs when set
  output logic      [16:0] per_out,  // Peripheral data
  output logic      [16:0] per_oe,   // Peripheral enables
  output logic      [31:0] pad_in    // Pad levels
);
  // One-hot marks: a wrong route shows a wrong level; a per_sel of 31 marks nothing
  assign per_out = {17{inv}} ^ (17'h0_0001 << per_sel);
  assign per_oe  = per_out;
  assign pad_in  = {32{inv}} ^ (32'h0000_0001 << pin_sel);
endmodule

// ---- verif/rpsel_top_props.sv ----
/*
  Checker for the pin select crossbar: lock behaviour, reset state and pad ownership.
  Assumes it is bound to rpsel_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module rpsel_top_props #(
  parameter int PKG_PINS = 44  // Package pin count, as in the design
) (
  input wire logic        CLK_SYS,
  input wire logic        SRST,
  input wire logic        CE,
  input wire logic [31:0] BOOT_CFG3,
  input wire logic        CFG_WR,
  input wire logic [31:0] CFG_WDATA,
  input wire logic        UNLOCK_OK,
  input wire logic        SEL_WR,
  input wire logic [5:0]  SEL_ADDR,
  input wire logic        SEL_WR_BLOCKED,
  input wire logic        MAP_LOCK,
  input wire logic        ONE_WAY,
  input wire logic [31:0] PAD_ANALOG,
  input wire logic [31:0] PAD_OUT,
  input wire logic [31:0] PAD_OE,
  input wire logic [31:0] PAD_REMAP_ACT,
  input wire logic [23:0] PERIPH_IN
);
  // Helpers, so that the sampled-value functions see plain signals
  wire boot_oneway = BOOT_CFG3[29];                                  // One-way bit of boot word
  wire wr_refused  = SEL_WR && (MAP_LOCK || SEL_ADDR[5:3] == 3'h3);  // Locked or unmapped write

  // One clock domain, so one default clock and disable
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  chk_reset_quiet: assert property (
    $fell(SRST) |-> (PAD_OE == '0 && PERIPH_IN == '0 && !MAP_LOCK)) else $error("not quiet");
  chk_boot_oneway: assert property (
    $fell(SRST) |-> ONE_WAY == $past(boot_oneway)) else $error("one-way flag wrong");
  chk_lock_set: assert property (
    CE && CFG_WR && UNLOCK_OK && CFG_WDATA[13] |=> MAP_LOCK) else $error("lock not set");
  chk_lock_clear: assert property (
    CE && CFG_WR && UNLOCK_OK && !CFG_WDATA[13] && !ONE_WAY |=> !MAP_LOCK)
    else $error("lock not cleared");
  chk_unlock_needed: assert property (
    !(CE && CFG_WR && UNLOCK_OK) |=> $stable(MAP_LOCK)) else $error("lock moved");
  chk_oneway_hold: assert property (
    MAP_LOCK && ONE_WAY |=> MAP_LOCK) else $error("one-way lock released");
  chk_locked_drop: assert property (
    CE && SEL_WR && MAP_LOCK |=> SEL_WR_BLOCKED) else $error("locked write not dropped");
  // A drop needs a write that was locked or unmapped
  chk_drop_cause: assert property (
    SEL_WR_BLOCKED |-> $past(wr_refused)) else $error("drop without cause");
  chk_analog_wins: assert property (
    $past(CE) |-> ($past(PAD_ANALOG) & (PAD_OE | PAD_REMAP_ACT)) == '0)
    else $error("remap over analog pin");
  chk_pad_owned: assert property (
    ((PAD_OE | PAD_OUT) & ~PAD_REMAP_ACT) == '0) else $error("pad driven unowned");
endmodule

bind rpsel_top rpsel_top_props #(.PKG_PINS(PKG_PINS)) u_props (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE), .BOOT_CFG3(BOOT_CFG3), .CFG_WR(CFG_WR),
  .CFG_WDATA(CFG_WDATA), .UNLOCK_OK(UNLOCK_OK), .SEL_WR(SEL_WR), .SEL_ADDR(SEL_ADDR),
  .SEL_WR_BLOCKED(SEL_WR_BLOCKED), .MAP_LOCK(MAP_LOCK), .ONE_WAY(ONE_WAY),
  .PAD_ANALOG(PAD_ANALOG), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE),
  .PAD_REMAP_ACT(PAD_REMAP_ACT), .PERIPH_IN(PERIPH_IN));

// ---- verif/tb_top.sv ----
/*
  Self-checking bench for the crossbar: reset state, input codes 0 to 8 and 15, every output code, lock.
  Assumes rpsel_pkg, the design and the far-side model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, cfg_wr = 1'b0, unl = 1'b0;
  logic        sel_wr = 1'b0, inv = 1'b0, blk, map_lock, one_way;
  logic [31:0] boot = 32'hFFFF_FFFF, cfg_wdata = 32'h0000_0000, pad_an = 32'h0000_0000;
  logic [31:0] pad_in, pad_out, pad_oe, pad_act, pad_act28;
  logic [5:0]  sel_addr = 6'h00, sel_raddr = 6'h00;
  logic [3:0]  sel_wdata = 4'h0, sel_rdata;
  logic [4:0]  fper = 5'h1F, fpin = 5'h00;
  logic [16:0] per_out, per_oe;
  logic [23:0] per_in, per_in28;
  int          miscompares = 0, tests_run = 0;
  // Expected peripheral index per pin set and code; 1F is no source
  logic [4:0]  tbl [4][8] = '{
    '{5'h1F, 5'h00, 5'h01, 5'h02, 5'h1F, 5'h03, 5'h1F, 5'h04},
    '{5'h1F, 5'h1F, 5'h1F, 5'h05, 5'h06, 5'h07, 5'h1F, 5'h08},
    '{5'h1F, 5'h1F, 5'h1F, 5'h05, 5'h06, 5'h09, 5'h0A, 5'h0B},
    '{5'h1F, 5'h0C, 5'h0D, 5'h1F, 5'h0E, 5'h0F, 5'h1F, 5'h10}};

  always #12.5 clk = ~clk;

  rpsel_top #(.PKG_PINS(44)) u_dut (.CLK_SYS(clk), .SRST(srst), .CE(ce), .BOOT_CFG3(boot),
    .CFG_WR(cfg_wr), .CFG_WDATA(cfg_wdata), .UNLOCK_OK(unl), .SEL_WR(sel_wr),
    .SEL_ADDR(sel_addr), .SEL_WDATA(sel_wdata), .SEL_RADDR(sel_raddr), .SEL_RDATA(sel_rdata),
    .SEL_WR_BLOCKED(blk), .MAP_LOCK(map_lock), .ONE_WAY(one_way), .PAD_IN(pad_in),
    .PAD_ANALOG(pad_an), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_REMAP_ACT(pad_act),
    .PERIPH_OUT(per_out), .PERIPH_OE(per_oe), .PERIPH_IN(per_in));
  // A 28-pin build on the same stimulus: codes 5 to 7 of every set have no pad there
  rpsel_top #(.PKG_PINS(28)) u_dut28 (.CLK_SYS(clk), .SRST(srst), .CE(ce), .BOOT_CFG3(boot),
    .CFG_WR(cfg_wr), .CFG_WDATA(cfg_wdata), .UNLOCK_OK(unl), .SEL_WR(sel_wr),
    .SEL_ADDR(sel_addr), .SEL_WDATA(sel_wdata), .SEL_RADDR(sel_raddr), .SEL_RDATA(),
    .SEL_WR_BLOCKED(), .MAP_LOCK(), .ONE_WAY(), .PAD_IN(pad_in),
    .PAD_ANALOG(pad_an), .PAD_OUT(), .PAD_OE(), .PAD_REMAP_ACT(pad_act28),
    .PERIPH_OUT(per_out), .PERIPH_OE(per_oe), .PERIPH_IN(per_in28));
  rpsel_far_model u_far (.per_sel(fper), .pin_sel(fpin), .inv(inv), .per_out(per_out),
    .per_oe(per_oe), .pad_in(pad_in));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Two edges: one to register the change, one to reach the outputs
  task automatic tick();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic far(input logic [4:0] pn, input logic [4:0] pr, input logic iv);
    @(posedge clk);
    fpin <= pn;
    fper <= pr;
    inv  <= iv;
  endtask
  task automatic wsel(input logic [5:0] a, input logic [3:0] d, output logic b);
    @(posedge clk);
    sel_wr    <= 1'b1;
    sel_addr  <= a;
    sel_wdata <= d;
    @(posedge clk);
    sel_wr <= 1'b0;
    #1 b = blk;
  endtask
  task automatic rsel(input logic [5:0] a, output logic [3:0] d);
    @(posedge clk);
    sel_raddr <= a;
    @(posedge clk);
    #1 d = sel_rdata;
  endtask
  // Lock writes drive the unlock flag to u together with the write strobe
  task automatic wcfg(input logic u, input logic lk);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    unl       <= u;
    cfg_wdata <= lk ? 32'h0000_2000 : 32'h0000_0000;
    @(posedge clk);
    cfg_wr <= 1'b0;
    unl    <= 1'b0;
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    #1;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic t_reset(input logic ow);
    logic [3:0] d;
    chk("map_lock", 32'h0, map_lock);
    chk("one_way", ow, one_way);
    chk("pad_oe", 32'h0, pad_oe);
    for (int a = 0; a < 64; a++) begin
      rsel(a[5:0], d);
      chk("selector", 32'h0, d);
    end
    $display("test reset done");
  endtask
  // Every input against every code of its pin set, reserved codes 1000 and 1111 included
  task automatic t_inputs();
    logic b;
    for (int k = 0; k < 24; k++) begin
      for (int i = 0; i < 10; i++) begin
        far({rpsel_pkg::IN_SET[k], i[2:0]}, 5'h1F, 1'b0);
        wsel(k[5:0], (i < 8) ? i[3:0] : (i == 8 ? 4'h8 : 4'hF), b);
        tick();
        chk("periph_in", i < 8, per_in[k]);
        chk("periph_in28", i < 5, per_in28[k]);
        far({rpsel_pkg::IN_SET[k], i[2:0]}, 5'h1F, 1'b1);
        tick();
        chk("periph_in", 32'h0, per_in[k]);
      end
    end
    $display("test inputs done");
  endtask
  task automatic t_outputs();
    logic [4:0] p;
    logic       b;
    for (int n = 0; n < 32; n++) begin
      for (int c = 0; c < 16; c++) begin
        p = (c < 8) ? tbl[n / 8][c] : 5'h1F;
        far(n[4:0], p, 1'b0);
        wsel(6'h20 + n[5:0], c[3:0], b);
        tick();
        chk("pad_out", p != 5'h1F, pad_out[n]);
        chk("pad_oe", p != 5'h1F, pad_oe[n]);
        chk("pad_act", p != 5'h1F, pad_act[n]);
        chk("pad_act28", p != 5'h1F && n % 8 < 5, pad_act28[n]);
        far(n[4:0], p, 1'b1);
        tick();
        chk("pad_out", 32'h0, pad_out[n] | pad_oe[n]);
      end
    end
    far(5'h01, 5'h00, 1'b0);
    wsel(6'h21, 4'h1, b);
    @(posedge clk);
    pad_an <= 32'h0000_0002;
    tick();
    chk("pad_oe", 32'h0, pad_oe[1]);
    @(posedge clk);
    pad_an <= 32'h0000_0000;
    $display("test outputs done");
  endtask
  task automatic t_lock();
    logic       b;
    logic [3:0] d;
    wsel(6'h00, 4'h3, b);
    wsel(6'h20, 4'h1, b);
    rsel(6'h00, d);
    chk("in_sel", 32'h3, d);
    wsel(6'h18, 4'h5, b);
    chk("blocked", 32'h1, b);
    wcfg(1'b0, 1'b1);
    chk("map_lock", 32'h0, map_lock);
    wcfg(1'b1, 1'b1);
    chk("map_lock", 32'h1, map_lock);
    wsel(6'h00, 4'h5, b);
    chk("blocked", 32'h1, b);
    rsel(6'h00, d);
    chk("in_sel", 32'h3, d);
    wcfg(1'b1, 1'b0);
    chk("map_lock", 32'h1, map_lock);
    @(posedge clk);
    boot <= 32'h0000_0000;
    do_reset();
    t_reset(1'b0);
    wcfg(1'b1, 1'b1);
    wcfg(1'b1, 1'b0);
    chk("map_lock", 32'h0, map_lock);
    wsel(6'h00, 4'h2, b);
    chk("blocked", 32'h0, b);
    $display("test lock done");
  endtask

  // Watchdog: the tests need about 6300 cycles
  initial begin
    #1_000_000;
    miscompares++;
    finish_test();
  end
  initial begin
    do_reset();
    t_reset(1'b1);
    t_inputs();
    t_outputs();
    t_lock();
    finish_test();
  end
endmodule
